// ---- verilog/fpas_pkg.sv ----
// constants for the floating-point add and subtract datapath
// Behaviour
// - align smaller exponent by single right shifts
// - alignment shifts replicate the coefficient sign
// - shifted-out bits kept in lower result field
// - 46 magnitude bits split into two halves
// - upper exponent is larger, plus right normalization
// - lower exponent is upper minus twenty-three
// - upper overflow gives indefinite, fixed lower exponent
// - lower exponent underflow gives machine zero lower
// - indefinite operand makes both results indefinite
// - subtract complements subtrahend before any alignment
// - specified method turns most-negative into half, exponent+1
// - extra sign bit complements most-negative in place
// - methods differ only in most-negative corner case
// - corner case behaviour chosen and documented
// - normalized forms start from unnormalized upper result
// - normalize shifts upper left until sign differs
// - exponent lowered by shift count, underflow zeroes
// - all-zero coefficient normalizes to machine zero
// - unnormalized zero coefficient keeps any exponent
// - 64-bit format scales every bit length
// - upper overflow shifts double result right once
// - lower result coefficient sign forced positive
package fpas_pkg;

    localparam int WORD_W        = 64;

    localparam int FP32_EW       = 8;
    localparam int FP32_CW       = 24;
    localparam int FP64_EW       = 16;
    localparam int FP64_CW       = 48;

    // exponent range: above MAX is indefinite, below MIN is machine zero
    localparam logic [7:0]  FP32_EXP_INDEF   = 8'h70;
    localparam logic [7:0]  FP32_EXP_ZERO    = 8'h80;
    localparam logic [7:0]  FP32_EXP_MAX     = 8'h6f;
    localparam logic [7:0]  FP32_EXP_MIN     = 8'h90;
    localparam logic [7:0]  FP32_LOW_OFS     = 8'h17;
    localparam logic [7:0]  FP32_OVF_LOW_EXP = 8'h59;

    localparam logic [15:0] FP64_EXP_INDEF   = 16'h7000;
    localparam logic [15:0] FP64_EXP_ZERO    = 16'h8000;
    localparam logic [15:0] FP64_EXP_MAX     = 16'h6fff;
    localparam logic [15:0] FP64_EXP_MIN     = 16'h9000;
    localparam logic [15:0] FP64_LOW_OFS     = 16'h002f;
    localparam logic [15:0] FP64_OVF_LOW_EXP = 16'h6fd1;

endpackage : fpas_pkg

// ---- verilog/fpas_unit.sv ----
// floating-point add/subtract datapath, 32-bit and 64-bit formats
`timescale 1ns/10ps

module fpas_core #(
    parameter int             EW          = fpas_pkg::FP32_EW,
    parameter int             CW          = fpas_pkg::FP32_CW,
    parameter logic [EW-1:0]  EXP_INDEF   = fpas_pkg::FP32_EXP_INDEF,
    parameter logic [EW-1:0]  EXP_ZERO    = fpas_pkg::FP32_EXP_ZERO,
    parameter logic [EW-1:0]  EXP_MAX     = fpas_pkg::FP32_EXP_MAX,
    parameter logic [EW-1:0]  EXP_MIN     = fpas_pkg::FP32_EXP_MIN,
    parameter logic [EW-1:0]  LOW_OFS     = fpas_pkg::FP32_LOW_OFS,
    parameter logic [EW-1:0]  OVF_LOW_EXP = fpas_pkg::FP32_OVF_LOW_EXP,
    parameter bit             EXTRA_SIGN  = 1'b1
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             load,
    input  wire logic             cplA,
    input  wire logic             cplB,
    input  wire logic             norm,
    input  wire logic [EW+CW-1:0] opndA,
    input  wire logic [EW+CW-1:0] opndB,
    output logic      [EW+CW-1:0] upperWord,
    output logic      [EW+CW-1:0] lowerWord
);
    import fpas_pkg::*;

    localparam int M  = CW - 1;
    localparam int AW = CW + 1 + M;
    localparam int SW = AW + 1;
    localparam int XW = EW + 2;
    localparam int NW = $clog2(CW);
    localparam logic [CW-1:0] MOST_NEG  = {1'b1, {(CW-1){1'b0}}};
    localparam logic [M-1:0]  LOW_ZERO  = '0;
    localparam logic [CW-1:0] COEF_ZERO = '0;

    function automatic logic signed [XW-1:0] widen(input logic [EW-1:0] e);
        widen = $signed({{2{e[EW-1]}}, e});
    endfunction : widen

    // returns {exponent increment, complemented coefficient with extra sign}
    function automatic logic [CW+1:0] complementCoef(input logic [CW-1:0] c,
                                                     input logic         doIt);
        logic [CW:0] ext;
        logic [CW:0] res;
        logic        inc;
        ext = {c[CW-1], c};
        res = ext;
        inc = 1'b0;
        if (doIt) begin
            if (!EXTRA_SIGN && c == MOST_NEG) begin
                res = -{ext[CW], ext[CW:1]};
                inc = 1'b1;
            end else begin
                res = -ext;
            end
        end
        complementCoef = {inc, res};
    endfunction : complementCoef

    // stage 1: complement, then align
    logic signed [EW-1:0] expRawA;
    logic signed [EW-1:0] expRawB;
    logic [CW-1:0]        coefRawA;
    logic [CW-1:0]        coefRawB;
    logic                 indefA;
    logic                 indefB;
    logic                 zeroA;
    logic                 zeroB;
    logic [CW+1:0]        cplOutA;
    logic [CW+1:0]        cplOutB;
    logic signed [XW-1:0] expA;
    logic signed [XW-1:0] expB;
    logic signed [XW-1:0] expDiff;
    logic [XW-1:0]        shiftAmt;
    logic signed [AW-1:0] fullA;
    logic signed [AW-1:0] fullB;

    logic [AW-1:0] alA_reg;
    logic [AW-1:0] alA_next;
    logic [AW-1:0] alB_reg;
    logic [AW-1:0] alB_next;
    logic [XW-1:0] exp_reg;
    logic [XW-1:0] exp_next;
    logic          indef_reg;
    logic          indef_next;
    logic          norm_reg;
    logic          norm_next;

    always_comb begin
        expRawA  = $signed(opndA[EW+CW-1:CW]);
        expRawB  = $signed(opndB[EW+CW-1:CW]);
        coefRawA = opndA[CW-1:0];
        coefRawB = opndB[CW-1:0];
        indefA   = widen(expRawA) > widen(EXP_MAX);
        indefB   = widen(expRawB) > widen(EXP_MAX);
        zeroA    = widen(expRawA) < widen(EXP_MIN);
        zeroB    = widen(expRawB) < widen(EXP_MIN);
        // a zero operand loses alignment so the other passes unchanged
        if (zeroA) begin
            expRawA  = $signed(EXP_ZERO);
            coefRawA = COEF_ZERO;
        end
        if (zeroB) begin
            expRawB  = $signed(EXP_ZERO);
            coefRawB = COEF_ZERO;
        end
        cplOutA = complementCoef(coefRawA, cplA);
        cplOutB = complementCoef(coefRawB, cplB);
        expA    = widen(expRawA) + $signed({{(XW-1){1'b0}}, cplOutA[CW+1]});
        expB    = widen(expRawB) + $signed({{(XW-1){1'b0}}, cplOutB[CW+1]});
        fullA   = $signed({cplOutA[CW:0], LOW_ZERO});
        fullB   = $signed({cplOutB[CW:0], LOW_ZERO});
        expDiff = expA - expB;
        alA_next   = alA_reg;
        alB_next   = alB_reg;
        exp_next   = exp_reg;
        indef_next = indef_reg;
        norm_next  = norm_reg;
        // one barrel shift equals the repeated single-bit steps
        if (expDiff >= 0) begin
            shiftAmt = expDiff;
        end else begin
            shiftAmt = -expDiff;
        end
        if (load) begin
            indef_next = indefA | indefB;
            norm_next  = norm;
            if (expDiff >= 0) begin
                exp_next = expA;
                alA_next = fullA;
                alB_next = fullB >>> shiftAmt;
            end else begin
                exp_next = expB;
                alA_next = fullA >>> shiftAmt;
                alB_next = fullB;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            alA_reg   <= '0;
            alB_reg   <= '0;
            exp_reg   <= '0;
            indef_reg <= 1'b0;
            norm_reg  <= 1'b0;
        end else begin
            alA_reg   <= alA_next;
            alB_reg   <= alB_next;
            exp_reg   <= exp_next;
            indef_reg <= indef_next;
            norm_reg  <= norm_next;
        end
    end

    // stage 2: add, right normalize, end cases, left normalize
    logic signed [SW-1:0] sum;
    logic signed [SW-1:0] dbl;
    logic                 rightNorm;
    logic signed [XW-1:0] expU;
    logic signed [XW-1:0] expL;
    logic signed [XW-1:0] expN;
    logic [CW-1:0]        upCoef;
    logic [M-1:0]         lowMag;
    logic [CW-1:0]        normCoef;
    logic [CW-1:0]        probe;
    logic [NW-1:0]        normCnt;
    logic                 normFound;

    always_comb begin
        sum = $signed({alA_reg[AW-1], alA_reg}) + $signed({alB_reg[AW-1], alB_reg});
        // upper field fits only while its top three bits agree
        rightNorm = !((sum[SW-1] == sum[SW-2]) && (sum[SW-2] == sum[SW-3]));
        dbl       = rightNorm ? (sum >>> 1) : sum;
        expU      = $signed(exp_reg) + $signed({{(XW-1){1'b0}}, rightNorm});
        upCoef    = dbl[M+CW-1:M];
        lowMag    = dbl[M-1:0];
        expL      = expU - widen(LOW_OFS);
        normCnt   = '0;
        normFound = 1'b0;
        normCoef  = upCoef;
        probe     = '0;
        // all ones needs every place up to CW-1 to reach the most negative value
        for (int i = 0; i < CW; i++) begin
            probe = upCoef << i;
            if (!normFound && (probe[CW-1] != probe[CW-2])) begin
                normCnt   = NW'(i);
                normCoef  = probe;
                normFound = 1'b1;
            end
        end
        expN = expU - $signed({{(XW-NW){1'b0}}, normCnt});
    end

    always_comb begin
        if (indef_reg) begin
            upperWord = {EXP_INDEF, COEF_ZERO};
            lowerWord = {EXP_INDEF, COEF_ZERO};
        end else if (expU > widen(EXP_MAX)) begin
            upperWord = {EXP_INDEF, COEF_ZERO};
            lowerWord = {OVF_LOW_EXP, 1'b0, lowMag};
        end else begin
            if (expL < widen(EXP_MIN)) begin
                lowerWord = {EXP_ZERO, COEF_ZERO};
            end else begin
                lowerWord = {expL[EW-1:0], 1'b0, lowMag};
            end
            if (!norm_reg) begin
                upperWord = {expU[EW-1:0], upCoef};
            end else if (!normFound || upCoef == COEF_ZERO) begin
                upperWord = {EXP_ZERO, COEF_ZERO};
            end else if (expN < widen(EXP_MIN)) begin
                upperWord = {EXP_ZERO, COEF_ZERO};
            end else begin
                upperWord = {expN[EW-1:0], normCoef};
            end
        end
    end

endmodule : fpas_core

module fpas_unit #(
    parameter bit EXTRA_SIGN = 1'b1
) (
    input  wire logic                        mclk,
    input  wire logic                        rst,
    input  wire logic                        reqValid,
    input  wire logic                        fmt64,
    input  wire logic                        opSub,
    input  wire logic                        opNegA,
    input  wire logic                        opNorm,
    input  wire logic [fpas_pkg::WORD_W-1:0] opndA,
    input  wire logic [fpas_pkg::WORD_W-1:0] opndB,
    output logic                             resValid,
    output logic      [fpas_pkg::WORD_W-1:0] resUpper,
    output logic      [fpas_pkg::WORD_W-1:0] resLower
);
    import fpas_pkg::*;

    localparam int W32 = FP32_EW + FP32_CW;
    localparam int W64 = FP64_EW + FP64_CW;

    logic [W32-1:0]    up32;
    logic [W32-1:0]    low32;
    logic [W64-1:0]    up64;
    logic [W64-1:0]    low64;
    logic              load32;
    logic              load64;

    logic              s1Valid_reg;
    logic              s1Valid_next;
    logic              s1Fmt_reg;
    logic              s1Fmt_next;
    logic              resValid_reg;
    logic              resValid_next;
    logic [WORD_W-1:0] resUpper_reg;
    logic [WORD_W-1:0] resUpper_next;
    logic [WORD_W-1:0] resLower_reg;
    logic [WORD_W-1:0] resLower_next;

    assign load32 = reqValid && !fmt64;
    assign load64 = reqValid && fmt64;

    fpas_core #(
        .EW          (FP32_EW),
        .CW          (FP32_CW),
        .EXP_INDEF   (FP32_EXP_INDEF),
        .EXP_ZERO    (FP32_EXP_ZERO),
        .EXP_MAX     (FP32_EXP_MAX),
        .EXP_MIN     (FP32_EXP_MIN),
        .LOW_OFS     (FP32_LOW_OFS),
        .OVF_LOW_EXP (FP32_OVF_LOW_EXP),
        .EXTRA_SIGN  (EXTRA_SIGN)
    ) core32 (
        .mclk      (mclk),
        .rst       (rst),
        .load      (load32),
        .cplA      (opNegA),
        .cplB      (opSub),
        .norm      (opNorm),
        .opndA     (opndA[W32-1:0]),
        .opndB     (opndB[W32-1:0]),
        .upperWord (up32),
        .lowerWord (low32)
    );

    // 64-bit format: same datapath with every length scaled
    fpas_core #(
        .EW          (FP64_EW),
        .CW          (FP64_CW),
        .EXP_INDEF   (FP64_EXP_INDEF),
        .EXP_ZERO    (FP64_EXP_ZERO),
        .EXP_MAX     (FP64_EXP_MAX),
        .EXP_MIN     (FP64_EXP_MIN),
        .LOW_OFS     (FP64_LOW_OFS),
        .OVF_LOW_EXP (FP64_OVF_LOW_EXP),
        .EXTRA_SIGN  (EXTRA_SIGN)
    ) core64 (
        .mclk      (mclk),
        .rst       (rst),
        .load      (load64),
        .cplA      (opNegA),
        .cplB      (opSub),
        .norm      (opNorm),
        .opndA     (opndA),
        .opndB     (opndB),
        .upperWord (up64),
        .lowerWord (low64)
    );

    always_comb begin
        s1Valid_next  = reqValid;
        s1Fmt_next    = s1Fmt_reg;
        resValid_next = s1Valid_reg;
        resUpper_next = resUpper_reg;
        resLower_next = resLower_reg;
        if (reqValid) begin
            s1Fmt_next = fmt64;
        end
        // results hold until the next one lands
        if (s1Valid_reg) begin
            if (s1Fmt_reg) begin
                resUpper_next = up64;
                resLower_next = low64;
            end else begin
                resUpper_next = {{(WORD_W-W32){1'b0}}, up32};
                resLower_next = {{(WORD_W-W32){1'b0}}, low32};
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            s1Valid_reg  <= 1'b0;
            s1Fmt_reg    <= 1'b0;
            resValid_reg <= 1'b0;
            resUpper_reg <= '0;
            resLower_reg <= '0;
        end else begin
            s1Valid_reg  <= s1Valid_next;
            s1Fmt_reg    <= s1Fmt_next;
            resValid_reg <= resValid_next;
            resUpper_reg <= resUpper_next;
            resLower_reg <= resLower_next;
        end
    end

    assign resValid = resValid_reg;
    assign resUpper = resUpper_reg;
    assign resLower = resLower_reg;

endmodule : fpas_unit

// ---- sim/fpas_properties.sv ----
// port checker for the float add/subtract unit
`timescale 1ns/10ps
module fpas_properties #(
    parameter bit EXTRA_SIGN = 1'b1
) (
    input wire logic                        mclk,
    input wire logic                        rst,
    input wire logic                        reqValid,
    input wire logic                        fmt64,
    input wire logic                        opSub,
    input wire logic                        opNegA,
    input wire logic                        opNorm,
    input wire logic [fpas_pkg::WORD_W-1:0] opndA,
    input wire logic [fpas_pkg::WORD_W-1:0] opndB,
    input wire logic                        resValid,
    input wire logic [fpas_pkg::WORD_W-1:0] resUpper,
    input wire logic [fpas_pkg::WORD_W-1:0] resLower
);
    import fpas_pkg::*;
    logic       req32;
    logic       reqNorm;
    logic       reqIndef;
    logic       plainIn;
    logic [7:0] maxExp;
    // field checks cover the 32-bit format only, except the lower sign check, which covers both; 64-bit shares the datapath
    assign req32    = reqValid && !fmt64 && !opNorm;
    assign reqNorm  = reqValid && !fmt64 && opNorm;
    assign reqIndef = reqValid && !fmt64 && (opndA[31:28] == 4'h7 || opndB[31:28] == 4'h7);
    assign plainIn  = req32 && !(opndA[31:28] inside {4'h7, 4'h8})
                      && !(opndB[31:28] inside {4'h7, 4'h8});
    assign maxExp   = ($signed(opndA[31:24]) > $signed(opndB[31:24])) ? opndA[31:24]
                                                                      : opndB[31:24];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    sequence s_take;
        reqValid;
    endsequence
    sequence s_answer;
        ##2 resValid;
    endsequence
    a_valid_latency:
        assert property (s_take |-> s_answer) else $error("result strobe late");
    a_no_spurious:
        assert property (resValid |-> $past(reqValid, 2)) else $error("stray result strobe");
    a_indef_both:
        assert property (reqIndef |-> ##2 resUpper[31:0] == 32'h7000_0000
                         && resLower[31:0] == 32'h7000_0000) else $error("indefinite lost");
    a_lower_sign:
        assert property (resValid |-> ($past(fmt64, 2) ? !resLower[47] : !resLower[23]))
        else $error("lower sign set");
    a_lower_offset:
        assert property (resValid && $past(req32, 2) && resUpper[31:28] != 4'h7
                         && resLower[31:24] != 8'h80
                         |-> resLower[31:24] == resUpper[31:24] - 8'h17)
        else $error("lower exponent offset wrong");
    a_ovf_lower:
        assert property (resValid && $past(req32, 2) && !$past(reqIndef, 2)
                         && resUpper[31:0] == 32'h7000_0000 |-> resLower[31:24] == 8'h59)
        else $error("overflow lower exponent wrong");
    a_upper_exp:
        assert property (resValid && $past(plainIn, 2) && resUpper[31:28] != 4'h7
                         |-> resUpper[31:24] == $past(maxExp, 2)
                         || resUpper[31:24] == $past(maxExp, 2) + 8'h01)
        else $error("upper exponent wrong");
    a_norm_shape:
        assert property (resValid && $past(reqNorm, 2) && resUpper[31:24] != 8'h80
                         && resUpper[31:28] != 4'h7 |-> resUpper[23] != resUpper[22])
        else $error("result not normalized");
    a_norm_zero:
        assert property (resValid && $past(reqNorm, 2) && resUpper[23:0] == 24'h0
                         |-> resUpper[31:24] == 8'h80 || resUpper[31:28] == 4'h7)
        else $error("zero not machine zero");
endmodule : fpas_properties

// ---- sim/fpas_issue_model.sv ----
// operand issue model standing for the processor side
`timescale 1ns/10ps
module fpas_issue_model (
    input  wire logic                   mclk,
    output logic                        reqValid,
    output logic                        fmt64,
    output logic                        opSub,
    output logic                        opNegA,
    output logic                        opNorm,
    output logic [fpas_pkg::WORD_W-1:0] opndA,
    output logic [fpas_pkg::WORD_W-1:0] opndB
);
    import fpas_pkg::*;
    initial begin
        reqValid = 1'b0;
        {fmt64, opSub, opNegA, opNorm} = 4'h0;
        opndA = '0;
        opndB = '0;
    end
    // keep holds the strobe so the next call forms a back-to-back burst
    task automatic issue(input logic [3:0] ops, input logic [WORD_W-1:0] a,
                         input logic [WORD_W-1:0] b, input bit keep);
        reqValid = 1'b1;
        {fmt64, opSub, opNegA, opNorm} = ops;
        opndA = a;
        opndB = b;
        @(posedge mclk);
        #1;
        if (!keep) begin
            // scrambled so a late sample cannot pass by luck
            reqValid = 1'b0;
            {fmt64, opSub, opNegA, opNorm} = ~ops;
            opndA = ~a;
            opndB = ~b;
        end
    endtask : issue
endmodule : fpas_issue_model

// ---- sim/testbench.sv ----
// self-checking bench for the float add/subtract unit
`timescale 1ns/10ps
module testbench;
    import fpas_pkg::*;
    localparam logic [3:0] ADD = 4'h0, NRM = 4'h1, NEG = 4'h2, SUB = 4'h4, F64 = 4'h8;
    logic              mclk, rst, reqValid, fmt64, opSub, opNegA, opNorm, resValid;
    logic [WORD_W-1:0] opndA, opndB, resUpper, resLower;
    logic              specValid;
    logic [WORD_W-1:0] specUpper, specLower;
    int                err_total, n_tests;
    fpas_issue_model P (.mclk(mclk), .reqValid(reqValid), .fmt64(fmt64), .opSub(opSub),
        .opNegA(opNegA), .opNorm(opNorm), .opndA(opndA), .opndB(opndB));
    fpas_unit DUT (.mclk(mclk), .rst(rst), .reqValid(reqValid), .fmt64(fmt64), .opSub(opSub),
        .opNegA(opNegA), .opNorm(opNorm), .opndA(opndA), .opndB(opndB),
        .resValid(resValid), .resUpper(resUpper), .resLower(resLower));
    // specified right-shift method for the most-negative corner, run alongside
    fpas_unit #(.EXTRA_SIGN(1'b0)) DUT_SPEC (.mclk(mclk), .rst(rst), .reqValid(reqValid),
        .fmt64(fmt64), .opSub(opSub), .opNegA(opNegA), .opNorm(opNorm), .opndA(opndA),
        .opndB(opndB), .resValid(specValid), .resUpper(specUpper), .resLower(specLower));
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict
    task automatic check_word(input string what, input logic [63:0] want, input logic [63:0] got);
        n_tests++;
        if (got !== want) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, want, got);
        end
    endtask : check_word
    task automatic check_flag(input string what, input logic want, input logic got);
        n_tests++;
        if (got !== want) begin
            err_total++;
            $display("MISMATCH %s expected %b seen %b", what, want, got);
        end
    endtask : check_flag
    task automatic run(input logic [3:0] ops, input logic [63:0] a, b, eu, el, input bit chkL);
        int i;
        P.issue(ops, a, b, 1'b0);
        for (i = 0; i < 4 && resValid !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        check_flag("resValid", 1'b1, resValid);
        check_word("resUpper", eu, resUpper);
        if (chkL) check_word("resLower", el, resLower);
    endtask : run
    task automatic r32(input logic [3:0] ops, input logic [31:0] a, b, eu, el, input bit chkL);
        run(ops, {32'h0, a}, {32'h0, b}, {32'h0, eu}, {32'h0, el}, chkL);
    endtask : r32
    task automatic t_align();
        r32(ADD, 32'h0140_0000, 32'h0000_0003, 32'h0140_0001, 32'hea40_0000, 1);
        r32(ADD, 32'h0240_0000, 32'h00ff_fffc, 32'h023f_ffff, 32'heb00_0000, 1);
        r32(ADD, 32'h0040_0001, 32'h0040_0000, 32'h0140_0000, 32'hea40_0000, 1);
    endtask : t_align
    task automatic t_end_cases();
        r32(ADD, 32'h6f40_0001, 32'h6f40_0000, 32'h7000_0000, 32'h5940_0000, 1);
        run(F64, 64'h6fff_4000_0000_0001, 64'h6fff_4000_0000_0000,
            64'h7000_0000_0000_0000, 64'h6fd1_4000_0000_0000, 1);
        r32(ADD, 32'h9040_0000, 32'h9000_0000, 32'h9040_0000, 32'h8000_0000, 1);
        r32(ADD, 32'h7000_0000, 32'h0140_0000, 32'h7000_0000, 32'h7000_0000, 1);
        r32(SUB, 32'h0140_0000, 32'h7f12_3456, 32'h7000_0000, 32'h7000_0000, 1);
    endtask : t_end_cases
    task automatic t_subtract();
        r32(SUB, 32'h0530_0000, 32'h0510_0000, 32'h0520_0000, 32'hee00_0000, 1);
        r32(SUB, 32'h0400_0001, 32'h0000_0001, 32'h0400_0000, 32'hed78_0000, 1);
        r32(NEG, 32'h0510_0000, 32'h0530_0000, 32'h0520_0000, 32'hee00_0000, 1);
        r32(SUB, 32'h60ff_f000, 32'h6480_0000, 32'h647f_ff00, 32'h4d00_0000, 1);
        r32(SUB, 32'h50ff_f000, 32'h6f80_0000, 32'h6f7f_ffff, 32'h587f_fff0, 1);
    endtask : t_subtract
    task automatic t_normalize();
        r32(NRM, 32'h0510_0000, 32'h0508_0000, 32'h0360_0000, 32'h0, 0);
        r32(NRM, 32'h05f0_0000, 32'h0500_0000, 32'h0280_0000, 32'h0, 0);
        r32(SUB | NRM, 32'h0510_0000, 32'h0510_0000, 32'h8000_0000, 32'h0, 0);
        r32(NRM, 32'h9110_0000, 32'h9108_0000, 32'h8000_0000, 32'h0, 0);
        r32(NRM, 32'h05ff_ffff, 32'h0500_0000, 32'hee80_0000, 32'h0, 0);
    endtask : t_normalize
    task automatic t_back_to_back();
        P.issue(ADD, 64'h0140_0000, 64'h0000_0003, 1'b1);
        P.issue(ADD, 64'h0000_0003, 64'h0140_0000, 1'b0);
        check_flag("resValid", 1'b1, resValid);
        check_word("resUpper", 64'h0140_0001, resUpper);
        @(posedge mclk);
        #1;
        check_flag("resValid", 1'b1, resValid);
        check_word("resUpper", 64'h0140_0001, resUpper);
        check_word("resLower", 64'hea40_0000, resLower);
    endtask : t_back_to_back
    task automatic t_spec_method();
        P.issue(SUB, 64'h60ff_f000, 64'h6480_0000, 1'b0);
        @(posedge mclk);
        #1;
        check_flag("specValid", 1'b1, specValid);
        check_word("specUpper", 64'h653f_ff80, specUpper);
        check_word("specLower", 64'h4e00_0000, specLower);
        P.issue(SUB, 64'h50ff_f000, 64'h6f80_0000, 1'b0);
        @(posedge mclk);
        #1;
        check_word("specUpper", 64'h7000_0000, specUpper);
        check_word("specLower", 64'h597f_fff8, specLower);
        P.issue(SUB, 64'h6000_0100, 64'h6480_0000, 1'b0);
        @(posedge mclk);
        #1;
        check_word("resUpper", 64'h6540_0008, resUpper);
        check_word("specUpper", 64'h6540_0008, specUpper);
    endtask : t_spec_method
    initial begin
        err_total = 0;
        n_tests = 0;
        rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        rst = 1'b0;
        @(posedge mclk);
        #1;
        check_flag("resValid", 1'b0, resValid);
        check_word("resUpper", 64'h0, resUpper);
        t_align();
        t_end_cases();
        t_subtract();
        t_normalize();
        t_back_to_back();
        t_spec_method();
        give_verdict();
    end
    // whole run is well under a hundred cycles
    initial begin
        #2000;
        err_total++;
        give_verdict();
    end
endmodule : testbench

bind fpas_unit fpas_properties #(.EXTRA_SIGN(EXTRA_SIGN)) u_props (.mclk(mclk), .rst(rst),
    .reqValid(reqValid), .fmt64(fmt64), .opSub(opSub), .opNegA(opNegA), .opNorm(opNorm),
    .opndA(opndA), .opndB(opndB), .resValid(resValid), .resUpper(resUpper),
    .resLower(resLower));
